// File: src/scps_cfg.svh
// constants for the system clock source and pll select block
`ifndef SCPS_CFG_SVH
`define SCPS_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SCPS_ADDR_CLOCK_DIVISOR_REG    12'h000
`define SCPS_ADDR_FBD       12'h004
`define SCPS_ADDR_STATUS    12'h008

// ----------------------------------------------------------------
// clock divisor and feedback register fields
// ----------------------------------------------------------------
`define SCPS_PRE_LSB        0
`define SCPS_PRE_MSB        4
`define SCPS_POST_LSB       6
`define SCPS_POST_MSB       7
`define SCPS_RCDIV_LSB      8
`define SCPS_RCDIV_MSB      10
`define SCPS_RCEN_BIT       11
`define SCPS_FBD_MSB        8

// ----------------------------------------------------------------
// reset values and configuration load wait
// ----------------------------------------------------------------
`define SCPS_CLOCK_DIVISOR_REG_RST     12'h000
`define SCPS_FBD_RST        9'h01E
`define SCPS_ERASED_SRC     3'h7
`define SCPS_ERASED_MODE    2'h3
`define SCPS_LOAD_WAIT      2'h3

// ----------------------------------------------------------------
// initial source codes and primary modes
// ----------------------------------------------------------------
`define SCPS_SRC_FRC        3'h7
`define SCPS_SRC_RSV_HI     3'h6
`define SCPS_SRC_LOW_POWER_RC_OSC       3'h5
`define SCPS_SRC_SEC        3'h4
`define SCPS_SRC_PRI_PLL    3'h3
`define SCPS_SRC_PRI        3'h2
`define SCPS_SRC_FRC_PLL    3'h1
`define SCPS_SRC_RSV_LO     3'h0
`define SCPS_MODE_HS        2'h2
`define SCPS_MODE_XT        2'h1
`define SCPS_MODE_EC        2'h0
`define SCPS_MODE_OFF       2'h3

// ----------------------------------------------------------------
// divider arithmetic
// ----------------------------------------------------------------
`define SCPS_N1_OFS         6'h02
`define SCPS_M_OFS          10'h002
`define SCPS_N2_BASE        4'h2
`define SCPS_N2_MAX         4'h8
`define SCPS_RC_BASE        9'h002
`define SCPS_ACC_MAX        12'hFFF

`endif

// File: src/scps_clock_select.sv
// system clock source select, fast rc postscaler and pll rate model
//
// Notes on behaviour
// RULE1: seven selectable system clock choices offered
// RULE2: fast rc postscaler divides 2 to 256
// RULE3: source taken from configuration fields at reset
// RULE4: primary mode 11 code table decoded
// RULE5: codes 011/010 pick primary, mode picks type
// RULE6: erased configuration starts on fast rc
// RULE7: instruction clock is oscillator divided by two
// RULE8: software keeps instruction clock at most 40 MHz
// RULE9: only primary or fast rc feed pll
// RULE10: prescale n1 2..33 from bits 4:0
// RULE11: software keeps vco input 0.8-8 MHz
// RULE12: vco multiplied by m from feedback field
// RULE13: postscale n2 of 2,4,8 from bits 7:6
// RULE14: pll output is input times m/(n1*n2)
// RULE15: encodings 0->n1 2, 0x1E->m 32, 0->n2 2
// RULE16: low power rc also references watchdog and monitor
// RULE17: pin function set by own configuration bit
// RULE18: n1 and m are field values plus two
`timescale 1ns/10ps

`include "scps_cfg.svh"

module scps_clock_select
  import scps_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire logic          ce,
  input  wire scps_apb_req_t apbReq,
  output logic        [31:0] prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          fastRcOsc,
  input  wire logic          primaryOscInPin,
  input  wire logic          secondaryOscInPin,
  input  wire logic          lowPowerRcOsc,
  input  wire logic    [2:0] initialSourceCfg,
  input  wire logic    [1:0] primaryModeCfg,
  input  wire logic          oscPinFunctionCfg,
  output logic               oscTick,
  output logic               instructionClock,
  output logic               instructionTick,
  output logic               lowPowerRefTick,
  output logic               primaryOutPinIsIo,
  output scps_sel_t          activeSel,
  output logic               pllActive
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  scps_state_t st_reg;
  scps_state_t st_next;

  logic [3:0]  srcEdge;
  logic        frcTick;
  logic        priTick;
  logic        secTick;
  logic        lprcEdge;
  logic [4:0]  pllPrescaleSel;
  logic [1:0]  pllPostscaleSel;
  logic [2:0]  rcPostscaleSel;
  logic        rcPostEn;
  logic [5:0]  n1;
  logic [9:0]  m;
  logic [3:0]  n2;
  logic [9:0]  pll_feedback_sel;
  logic [8:0]  rcLimit;
  logic        pllInTick;
  logic        rawTick;
  logic [12:0] accSum;
  logic        setup;
  logic        mapped;
  logic        wrEn;
  logic [31:0] rdValue;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // oscillators are free running and foreign, so only synced copies are read
  assign srcEdge  = st_reg.syncB & ~st_reg.syncC;
  assign frcTick  = srcEdge[0];
  assign priTick  = srcEdge[1];
  assign secTick  = srcEdge[2];
  assign lprcEdge = srcEdge[3];

  assign pllPrescaleSel  = st_reg.clockDivisor[`SCPS_PRE_MSB:`SCPS_PRE_LSB];    // [RULE10]
  assign pllPostscaleSel = st_reg.clockDivisor[`SCPS_POST_MSB:`SCPS_POST_LSB];  // [RULE13]
  assign rcPostscaleSel  = st_reg.clockDivisor[`SCPS_RCDIV_MSB:`SCPS_RCDIV_LSB]; // [RULE2]
  assign rcPostEn        = st_reg.clockDivisor[`SCPS_RCEN_BIT];

  assign n1 = {1'b0, pllPrescaleSel} + `SCPS_N1_OFS;            // [RULE18] [RULE15]
  assign m  = {1'b0, st_reg.pllFeedback} + `SCPS_M_OFS;         // [RULE18] [RULE12]

  // code 10 is not a documented ratio; it is treated as the slowest
  always_comb begin
    case (pllPostscaleSel)                                       // [RULE13] [RULE15]
      2'h0:    n2 = `SCPS_N2_BASE;
      2'h1:    n2 = `SCPS_N2_BASE << 1;
      default: n2 = `SCPS_N2_MAX;
    endcase
  end

  assign pll_feedback_sel  = {4'h0, n1} * {6'h00, n2};                     // [RULE14]
  assign rcLimit = `SCPS_RC_BASE << rcPostscaleSel;             // [RULE2]

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  always_comb begin
    case (st_reg.initialSource)                                  // [RULE4] [RULE5]
      `SCPS_SRC_FRC:     activeSel = rcPostEn ? SCPS_SEL_FRC_DIV : SCPS_SEL_FRC; // [RULE1]
      `SCPS_SRC_LOW_POWER_RC_OSC:    activeSel = SCPS_SEL_LOW_POWER_RC_OSC;
      `SCPS_SRC_SEC:     activeSel = SCPS_SEL_SEC;
      `SCPS_SRC_PRI_PLL: activeSel = SCPS_SEL_PRI_PLL;
      `SCPS_SRC_PRI:     activeSel = SCPS_SEL_PRI;
      `SCPS_SRC_FRC_PLL: activeSel = SCPS_SEL_FRC_PLL;
      // reserved codes fall back to the internal fast rc so the core still runs
      default:           activeSel = SCPS_SEL_FRC;
    endcase
  end

  assign pllActive = (activeSel == SCPS_SEL_FRC_PLL) || (activeSel == SCPS_SEL_PRI_PLL);
  // only primary or fast rc can reach the pll; others bypass it
  assign pllInTick = (activeSel == SCPS_SEL_PRI_PLL) ? priTick : frcTick; // [RULE9]

  always_comb begin
    case (activeSel)
      SCPS_SEL_FRC_DIV: rawTick = st_reg.rcTick;                // [RULE2]
      SCPS_SEL_PRI:     rawTick = priTick;                      // [RULE5]
      SCPS_SEL_SEC:     rawTick = secTick;
      SCPS_SEL_LOW_POWER_RC_OSC:    rawTick = lprcEdge;
      default:          rawTick = frcTick;
    endcase
  end

  // rate model: m credits per input edge, one output per n1*n2 credits;
  // output is capped at one per clk, so the model saturates above that
  assign accSum = {1'b0, st_reg.pllAcc} + (pllInTick ? {3'h0, m} : 13'h0000); // [RULE14]

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  assign setup  = apbReq.psel && !apbReq.penable;
  assign mapped = (apbReq.paddr == `SCPS_ADDR_CLOCK_DIVISOR_REG) ||
                  (apbReq.paddr == `SCPS_ADDR_FBD) ||
                  (apbReq.paddr == `SCPS_ADDR_STATUS);
  assign wrEn   = apbReq.psel && apbReq.penable && apbReq.pwrite && ce;

  always_comb begin
    case (apbReq.paddr)
      `SCPS_ADDR_CLOCK_DIVISOR_REG: rdValue = {20'h00000, st_reg.clockDivisor};
      `SCPS_ADDR_FBD:    rdValue = {23'h000000, st_reg.pllFeedback};
      `SCPS_ADDR_STATUS: rdValue = {9'h000, n1, m, pllActive,
                                    st_reg.oscPinFunction, st_reg.primaryMode,
                                    st_reg.initialSource};
      default:           rdValue = 32'h00000000;
    endcase
  end

  // read data is latched in setup so the access phase never waits
  assign pready  = 1'b1;
  assign pslverr = apbReq.psel && apbReq.penable && !mapped;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.syncA = {lowPowerRcOsc, secondaryOscInPin, primaryOscInPin, fastRcOsc};
    st_next.syncB = st_reg.syncA;
    st_next.syncC = st_reg.syncB;
    st_next.cfgA  = {oscPinFunctionCfg, primaryModeCfg, initialSourceCfg};
    st_next.cfgB  = st_reg.cfgA;

    // configuration is caught once, after the synchroniser has filled
    if (!st_reg.loaded) begin
      if (st_reg.loadCnt == `SCPS_LOAD_WAIT) begin
        st_next.loaded         = 1'b1;
        st_next.initialSource  = st_reg.cfgB[2:0];               // [RULE3]
        st_next.primaryMode    = st_reg.cfgB[4:3];               // [RULE3]
        st_next.oscPinFunction = st_reg.cfgB[5];                 // [RULE17]
      end else begin
        st_next.loadCnt = st_reg.loadCnt + 2'h1;
      end
    end

    st_next.rcTick = 1'b0;
    if (frcTick) begin
      if (st_reg.rcCnt == 8'(rcLimit - 9'h001)) begin            // [RULE2]
        st_next.rcCnt  = 8'h00;
        st_next.rcTick = 1'b1;
      end else begin
        st_next.rcCnt = st_reg.rcCnt + 8'h01;
      end
    end

    if (pllActive) begin
      if (accSum >= {3'h0, pll_feedback_sel}) begin
        st_next.oscTick = 1'b1;                                  // [RULE14]
        st_next.pllAcc  = 12'(accSum - {3'h0, pll_feedback_sel});
      end else begin
        st_next.oscTick = 1'b0;
        st_next.pllAcc  = accSum[11:0];
      end
      if (accSum > {1'b0, `SCPS_ACC_MAX}) begin
        st_next.pllAcc = `SCPS_ACC_MAX;
      end
    end else begin
      st_next.oscTick = rawTick;                                 // [RULE9]
      st_next.pllAcc  = 12'h000;
    end

    st_next.icTick = 1'b0;
    if (st_reg.oscTick) begin
      st_next.icLevel = !st_reg.icLevel;                         // [RULE7]
      st_next.icTick  = st_reg.icLevel;                          // [RULE7]
    end

    st_next.lprcTick = lprcEdge;                                 // [RULE16]

    if (setup) begin
      st_next.prdata = rdValue;
    end
    if (wrEn && apbReq.paddr == `SCPS_ADDR_CLOCK_DIVISOR_REG) begin
      st_next.clockDivisor = apbReq.pwdata[11:0];
    end
    if (wrEn && apbReq.paddr == `SCPS_ADDR_FBD) begin
      st_next.pllFeedback = apbReq.pwdata[`SCPS_FBD_MSB:0];      // [RULE12]
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg                <= '0;
      st_reg.initialSource  <= `SCPS_ERASED_SRC;                 // [RULE6]
      st_reg.primaryMode    <= `SCPS_ERASED_MODE;                // [RULE6]
      st_reg.clockDivisor   <= `SCPS_CLOCK_DIVISOR_REG_RST;
      st_reg.pllFeedback    <= `SCPS_FBD_RST;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata            = st_reg.prdata;
  assign oscTick           = st_reg.oscTick;
  assign instructionClock  = st_reg.icLevel;
  assign instructionTick   = st_reg.icTick;
  assign lowPowerRefTick   = st_reg.lprcTick;
  assign primaryOutPinIsIo = st_reg.oscPinFunction;

endmodule

// File: src/scps_pkg.sv
// types for the system clock source and pll select block
package scps_pkg;

  // apb request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } scps_apb_req_t;

  // oscillator selections that the block can run on
  typedef enum logic [2:0] {
    SCPS_SEL_FRC,
    SCPS_SEL_FRC_DIV,
    SCPS_SEL_FRC_PLL,
    SCPS_SEL_PRI,
    SCPS_SEL_PRI_PLL,
    SCPS_SEL_SEC,
    SCPS_SEL_LOW_POWER_RC_OSC
  } scps_sel_t;

  typedef struct packed {
    logic [3:0]  syncA;
    logic [3:0]  syncB;
    logic [3:0]  syncC;
    logic [5:0]  cfgA;
    logic [5:0]  cfgB;
    logic [1:0]  loadCnt;
    logic        loaded;
    logic [2:0]  initialSource;
    logic [1:0]  primaryMode;
    logic        oscPinFunction;
    logic [11:0] clockDivisor;
    logic [8:0]  pllFeedback;
    logic [7:0]  rcCnt;
    logic        rcTick;
    logic [11:0] pllAcc;
    logic        oscTick;
    logic        icLevel;
    logic        icTick;
    logic        lprcTick;
    logic [31:0] prdata;
  } scps_state_t;

endpackage

// File: tb/scps_clock_select_bench.sv
// self-checking bench for the clock select block
`timescale 1ns/10ps
module scps_clock_select_bench
  import scps_pkg::*;
();
  // ----------------------------------------
  // signals and design
  // ----------------------------------------
  logic          clk, sysRst, pinCfg, err, ceOn;
  logic          pready, pslverr, oscTick, icLvl, icTick, lprTick, pinIo, pllOn;
  logic [31:0]   prdata, rd;
  logic [3:0]    oscIn;
  logic [2:0]    srcCfg;
  logic [1:0]    modeCfg;
  scps_sel_t     sel;
  scps_apb_req_t req;
  int            failures = 0, samplesChecked = 0, nOsc = 0, nIc = 0, nLpr = 0;
  // clock_divisor_reg, feedback, edges, expected ticks; every row leaves no credit behind
  logic [31:0]   tab [5][4] = '{'{32'h000, 32'h01E, 32'h4, 32'h20},
    '{32'h040, 32'h01E, 32'h4, 32'h10}, '{32'h080, 32'h01E, 32'h4, 32'h8},
    '{32'h001, 32'h01E, 32'h3, 32'h10}, '{32'h01F, 32'h040, 32'h4, 32'h4}};

  scps_clock_select i_scps_clock_select (
    .clk(clk), .sys_rst(sysRst), .ce(ceOn), .apbReq(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fastRcOsc(oscIn[0]), .primaryOscInPin(oscIn[1]),
    .secondaryOscInPin(oscIn[2]), .lowPowerRcOsc(oscIn[3]), .initialSourceCfg(srcCfg),
    .primaryModeCfg(modeCfg), .oscPinFunctionCfg(pinCfg), .oscTick(oscTick),
    .instructionClock(icLvl), .instructionTick(icTick), .lowPowerRefTick(lprTick),
    .primaryOutPinIsIo(pinIo), .activeSel(sel), .pllActive(pllOn));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    nOsc <= nOsc + (oscTick === 1'b1);
    nIc <= nIc + (icTick === 1'b1);
    nLpr <= nLpr + (lprTick === 1'b1);
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic complete_run;
    $display("checks %0d failures %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    req <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    req <= '0;
    if (n >= 20) begin
      failures++;
      complete_run;
    end
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic boot(input logic [2:0] s, input logic [1:0] m, input logic p);
    srcCfg <= s;
    modeCfg <= m;
    pinCfg <= p;
    sysRst <= 1'b1;
    repeat (3) @(posedge clk);
    sysRst <= 1'b0;
    repeat (12) @(posedge clk);
  endtask

  // oscillator pins idle low between bursts, as an unselected source would
  task automatic run(input int p, input int n, input int exp);
    int o, i, l;
    o = nOsc;
    i = nIc;
    l = nLpr;
    repeat (n) begin
      oscIn[p] <= 1'b1;
      repeat (10) @(posedge clk);
      oscIn[p] <= 1'b0;
      repeat (10) @(posedge clk);
    end
    repeat (20) @(posedge clk);
    chk(nOsc - o, exp);
    chk(nIc - i, exp / 2);
    chk(nLpr - l, (p == 3) ? n : 0);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    scps_sel_t exSel;
    logic      pll;
    int        pin;
    req = '0;
    ceOn = 1'b1;
    oscIn = '0;
    srcCfg = 3'h7;
    modeCfg = 2'h3;
    pinCfg = 1'b0;
    sysRst = 1'b1;
    for (int s = 0; s < 8; s++) begin
      for (int m = 0; m < 4; m++) begin
        if ((s == 2 || s == 3) != (m != 3)) continue;
        boot(3'(s), 2'(m), s[0]);
        exSel = (s == 5) ? SCPS_SEL_LOW_POWER_RC_OSC : (s == 4) ? SCPS_SEL_SEC :
          (s == 3) ? SCPS_SEL_PRI_PLL : (s == 2) ? SCPS_SEL_PRI :
          (s == 1) ? SCPS_SEL_FRC_PLL : SCPS_SEL_FRC;
        pin = (s == 5) ? 3 : (s == 4) ? 2 : (s == 2 || s == 3) ? 1 : 0;
        pll = (s == 1 || s == 3);
        chk(sel, exSel);
        chk(pllOn, pll);
        chk(pinIo, s[0]);
        rdchk(12'h008, {9'h0, 6'h02, 10'h020, pll, s[0], 2'(m), 3'(s)});
        run(pin, 4, pll ? 32 : 4);
      end
    end
    boot(3'h1, 2'h3, 1'b0);
    for (int r = 0; r < 5; r++) begin
      apb(1'b1, 12'h000, tab[r][0]);
      apb(1'b1, 12'h004, tab[r][1]);
      run(0, tab[r][2], tab[r][3]);
    end
    rdchk(12'h008, {9'h0, 6'h21, 10'h042, 1'b1, 1'b0, 2'h3, 3'h1});
    boot(3'h7, 2'h3, 1'b0);
    rdchk(12'h000, 32'h0);
    rdchk(12'h004, 32'h01E);
    rdchk(12'h00C, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, 12'h000, 32'h800);
    // the write lands on the edge that ends the access, so look one edge later
    @(posedge clk);
    chk(sel, SCPS_SEL_FRC_DIV);
    run(0, 4, 2);
    apb(1'b1, 12'h000, 32'hFFFFF900);
    rdchk(12'h000, 32'h900);
    run(0, 8, 2);
    apb(1'b1, 12'h000, 32'hF00);
    run(0, 512, 2);
    // a write with the clock enable low must be dropped
    ceOn <= 1'b0;
    apb(1'b1, 12'h004, 32'h040);
    ceOn <= 1'b1;
    rdchk(12'h004, 32'h01E);
    complete_run;
  end
endmodule

// File: tb/scps_clock_select_properties.sv
// checker for the clock select block
`timescale 1ns/10ps
module scps_clock_select_chk
  import scps_pkg::*;
(
  input wire logic          clk,
  input wire logic          sys_rst,
  input wire scps_apb_req_t apbReq,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          fastRcOsc,
  input wire logic          lowPowerRcOsc,
  input wire logic          oscTick,
  input wire logic          instructionClock,
  input wire logic          instructionTick,
  input wire logic          lowPowerRefTick,
  input wire scps_sel_t     activeSel,
  input wire logic          pllActive
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // pin edge crosses a two-flop synchroniser, so allow a short window
  sequence sRcEdge;
    $rose(fastRcOsc) && activeSel == SCPS_SEL_FRC;
  endsequence
  sequence sTickSoon;
    ##[3:5] oscTick;
  endsequence

  AST_FRC_PATH: assert property (sRcEdge |-> sTickSoon)
    else $error("fast rc edge gave no oscillator tick");
  AST_LOW_POWER_RC_OSC_REF: assert property ($rose(lowPowerRcOsc) |-> ##[3:5] lowPowerRefTick)
    else $error("low power rc edge gave no reference tick");
  AST_LPR_PULSE: assert property (lowPowerRefTick |=> !lowPowerRefTick)
    else $error("reference tick longer than one cycle");
  AST_IC_TOGGLE: assert property (oscTick |=> instructionClock != $past(instructionClock))
    else $error("instruction clock missed a toggle");
  AST_IC_HOLD: assert property (!oscTick |=> $stable(instructionClock))
    else $error("instruction clock moved without a tick");
  AST_IC_TICK: assert property (instructionTick |-> $past(oscTick))
    else $error("instruction tick without oscillator tick");
  AST_PLL_FLAG: assert property (pllActive == (activeSel inside {SCPS_SEL_FRC_PLL, SCPS_SEL_PRI_PLL}))
    else $error("pll flag disagrees with selection");
  AST_SEL_LEGAL: assert property (activeSel <= SCPS_SEL_LOW_POWER_RC_OSC)
    else $error("selection outside the seven choices");
  AST_RST_SEL: assert property ($fell(sys_rst) |-> activeSel == SCPS_SEL_FRC && !instructionClock)
    else $error("reset did not start on fast rc");
  AST_ERR_MAP: assert property (apbReq.psel && apbReq.penable |-> pready && pslverr == !(apbReq.paddr inside {12'h000, 12'h004, 12'h008}))
    else $error("bus error flag wrong");
endmodule

bind scps_clock_select scps_clock_select_chk i_scps_clock_select_chk (
  .clk(clk), .sys_rst(sys_rst), .apbReq(apbReq), .pready(pready), .pslverr(pslverr),
  .fastRcOsc(fastRcOsc), .lowPowerRcOsc(lowPowerRcOsc), .oscTick(oscTick),
  .instructionClock(instructionClock), .instructionTick(instructionTick),
  .lowPowerRefTick(lowPowerRefTick), .activeSel(activeSel), .pllActive(pllActive)
);
